// file: design/mtu_pkg.sv
package mtu_pkg;
    localparam int NCH = 5;
    localparam int CW = 16;
    localparam int EXT_N = 4;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hffff;
    localparam logic [2:0] SRC_CLK = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_LOW = 3'h1;
    localparam logic [2:0] FN_HIGH = 3'h2;
    localparam logic [2:0] FN_TOG = 3'h3;
    localparam int FN_CAP_BIT = 2;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_RSYNC = 2'h1;
    localparam logic [1:0] MODE_COMP = 2'h2;
    localparam int FLG_A = 0;
    localparam int FLG_B = 1;
    localparam int FLG_WRAP = 2;
    localparam int CH_NOTOG = 2;
    localparam int CH_P = 3;
    localparam int CH_Q = 4;

    typedef struct packed {
        logic [2:0] count_source_select;
        logic [1:0] external_edge_select;
        logic [1:0] counter_clear_source;
        logic [2:0] pin_fn_a;
        logic [2:0] pin_fn_b;
        logic [2:0] irq_en;
    } mtu_cfg_s;

    localparam mtu_cfg_s CFG_RST = '{count_source_select: SRC_CLK,
        external_edge_select: EDGE_RISE, counter_clear_source: CLR_NONE,
        pin_fn_a: FN_NONE, pin_fn_b: FN_NONE, irq_en: 3'h0};

    typedef struct packed {
        logic [NCH-1:0][CW-1:0] cnt;
        logic [NCH-1:0][CW-1:0] general_register_a;
        logic [NCH-1:0][CW-1:0] general_register_b;
        logic [NCH-1:0][CW-1:0] bra;
        logic [NCH-1:0][CW-1:0] brb;
        mtu_cfg_s [NCH-1:0] cfg;
        logic [NCH-1:0][2:0] flg;
        logic [NCH-1:0][2:0] armed;
        logic [NCH-1:0] pin_a;
        logic [NCH-1:0] pin_b;
        logic down;
        logic [2:0] pre;
    } mtu_state_s;

    localparam mtu_state_s ST_RST = '{cnt: {NCH{CNT_RST}},
        general_register_a: {NCH{GR_RST}}, general_register_b: {NCH{GR_RST}}, bra: {NCH{GR_RST}},
        brb: {NCH{GR_RST}}, cfg: {NCH{CFG_RST}}, flg: '0, armed: '0,
        pin_a: '0, pin_b: '0, down: 1'b0, pre: 3'h0};
endpackage : mtu_pkg

// file: design/mtu_pin_sync.sv
`timescale 1ns/1ps
module mtu_pin_sync #(
    parameter int W = 14
) (
    input wire logic clk_i,          // Core clock
    input wire logic rst_i,          // Async reset, high
    input wire logic [W-1:0] pin_i,  // Raw pins
    output logic [W-1:0] rise_o,     // One-cycle rising edge
    output logic [W-1:0] fall_o      // One-cycle falling edge
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } mtu_sync_s;

    mtu_sync_s s;
    mtu_sync_s next_s;

    always_comb begin
        next_s.s1 = pin_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    // Only s2/s3 feed edge logic; s1 may be metastable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise_o = s.s2 & ~s.s3;
    assign fall_o = ~s.s2 & s.s3;
endmodule : mtu_pin_sync

// file: design/mtu_timer.sv
`timescale 1ns/1ps
module mtu_timer (
    input wire logic CORE_CLK_I,                    // 200 MHz core clock
    input wire logic SYS_RST_I,                     // Async reset, high
    input wire logic [4:0] RUN_I,                   // channel_run_bits
    input wire logic [4:0] SYNC_I,                  // Synchronized channels
    input wire logic [4:0] PWM_I,                   // Per-channel PWM mode
    input wire logic [1:0] MODE_I,                  // Channel 3/4 pair mode
    input wire logic [4:0] BUF_A_I,                 // Buffer A enable
    input wire logic [4:0] BUF_B_I,                 // Buffer B enable
    input wire logic [4:0] CFG_WR_I,                // Config write strobe
    input wire mtu_pkg::mtu_cfg_s CFG_I,            // Config data
    input wire logic [15:0] WR_DATA_I,              // Shared write data
    input wire logic [4:0] CNT_WR_I,                // Counter write
    input wire logic [4:0] GRA_WR_I,                // Register A write
    input wire logic [4:0] GRB_WR_I,                // Register B write
    input wire logic [4:0] BRA_WR_I,                // Buffer A write
    input wire logic [4:0] BRB_WR_I,                // Buffer B write
    input wire logic [4:0] FLAG_RD_I,               // Flag register read
    input wire logic [4:0] FLAG_CLR_I,              // Flag register write
    input wire logic [2:0] FLAG_WDATA_I,            // Flag write data
    input wire logic [3:0] EXT_CLK_I,               // external_count_inputs
    input wire logic [4:0] PIN_A_I,                 // channel_pin_a input
    input wire logic [4:0] PIN_B_I,                 // channel_pin_b input
    output logic [4:0][15:0] CNT_O,                 // Counters
    output logic [4:0][15:0] GRA_O,                 // General registers A
    output logic [4:0][15:0] GRB_O,                 // General registers B
    output logic [4:0][15:0] BRA_O,                 // Buffer registers A
    output logic [4:0][15:0] BRB_O,                 // Buffer registers B
    output logic [4:0][2:0] FLAG_O,                 // Flags: wrap, B, A
    output logic [4:0] IRQ_O,                       // Interrupt request
    output logic [4:0] PIN_A_O,                     // channel_pin_a output
    output logic [4:0] PIN_A_OE_N_O,                // Pin A drive, low
    output logic [4:0] PIN_B_O,                     // channel_pin_b output
    output logic [4:0] PIN_B_OE_N_O                 // Pin B drive, low
);
    localparam int NCH = mtu_pkg::NCH;
    localparam int PW = mtu_pkg::EXT_N + 2 * NCH;

    mtu_pkg::mtu_state_s s;
    mtu_pkg::mtu_state_s next_s;
    logic [PW-1:0] rise;
    logic [PW-1:0] fall;
    logic [NCH-1:0] tick;
    logic [NCH-1:0] mt_a;
    logic [NCH-1:0] mt_b;
    logic [NCH-1:0] cap_am;
    logic [NCH-1:0] cap_bm;
    logic [NCH-1:0] cap_a;
    logic [NCH-1:0] cap_b;
    logic [NCH-1:0] own_clr;
    logic sync_clr;
    logic wr_sync;
    logic rev_dn;
    logic rev_up;
    logic mode_xfer;

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r, input logic f);
        if (sel == mtu_pkg::EDGE_RISE) begin
            return r;
        end else if (sel == mtu_pkg::EDGE_FALL) begin
            return f;
        end
        return r | f;
    endfunction : edge_hit

    function automatic logic src_tick(input logic [2:0] sel,
                                      input logic [2:0] pre,
                                      input logic [3:0] ext);
        unique case (sel)
            mtu_pkg::SRC_CLK: return 1'b1;
            mtu_pkg::SRC_DIV2: return pre[0];
            mtu_pkg::SRC_DIV4: return &pre[1:0];
            mtu_pkg::SRC_DIV8: return &pre;
            default: return ext[sel[1:0]];
        endcase
    endfunction : src_tick

    function automatic logic pin_lvl(input logic [2:0] fn,
                                     input logic cur, input logic tog_ok);
        unique case (fn)
            mtu_pkg::FN_LOW: return 1'b0;
            mtu_pkg::FN_HIGH: return 1'b1;
            mtu_pkg::FN_TOG: return tog_ok ? ~cur : cur;
            default: return cur;
        endcase
    endfunction : pin_lvl

    mtu_pin_sync #(
        .W(PW)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .pin_i({PIN_B_I, PIN_A_I, EXT_CLK_I}),
        .rise_o(rise),
        .fall_o(fall)
    );

    // Event decode: ticks, matches, captures, clears
    always_comb begin
        mtu_pkg::mtu_cfg_s cf;
        logic forced;
        logic [3:0] ext_v;
        cf = mtu_pkg::CFG_RST;
        forced = 1'b0;
        ext_v = 4'h0;
        for (int c = 0; c < NCH; c++) begin
            cf = s.cfg[c];
            forced = PWM_I[c] || (MODE_I != mtu_pkg::MODE_NORMAL &&
                     (c == mtu_pkg::CH_P || c == mtu_pkg::CH_Q));
            for (int k = 0; k < mtu_pkg::EXT_N; k++) begin
                ext_v[k] = edge_hit(cf.external_edge_select, rise[k],
                                    fall[k]);
            end
            tick[c] = RUN_I[c] && src_tick(cf.count_source_select, s.pre,
                                           ext_v);
            cap_am[c] = cf.pin_fn_a[mtu_pkg::FN_CAP_BIT] && !forced;
            cap_bm[c] = cf.pin_fn_b[mtu_pkg::FN_CAP_BIT] && !forced;
            // Match fires as the counter leaves the value
            mt_a[c] = tick[c] && !cap_am[c] && s.cnt[c] == s.general_register_a[c];
            mt_b[c] = tick[c] && !cap_bm[c] && s.cnt[c] == s.general_register_b[c];
            cap_a[c] = cap_am[c] && edge_hit(cf.pin_fn_a[1:0],
                rise[mtu_pkg::EXT_N + c], fall[mtu_pkg::EXT_N + c]);
            cap_b[c] = cap_bm[c] && edge_hit(cf.pin_fn_b[1:0],
                rise[mtu_pkg::EXT_N + NCH + c],
                fall[mtu_pkg::EXT_N + NCH + c]);
            own_clr[c] = (cf.counter_clear_source == mtu_pkg::CLR_A &&
                          (mt_a[c] || cap_a[c])) ||
                         (cf.counter_clear_source == mtu_pkg::CLR_B &&
                          (mt_b[c] || cap_b[c])) ||
                         (c == mtu_pkg::CH_P && mt_a[c] &&
                          MODE_I == mtu_pkg::MODE_RSYNC);
        end
    end

    assign sync_clr = |(own_clr & SYNC_I);
    assign wr_sync = |(CNT_WR_I & SYNC_I);
    assign rev_dn = MODE_I == mtu_pkg::MODE_COMP && !s.down &&
                    mt_a[mtu_pkg::CH_P];
    assign rev_up = MODE_I == mtu_pkg::MODE_COMP && s.down &&
                    tick[mtu_pkg::CH_Q] && s.cnt[mtu_pkg::CH_Q] == '0;
    assign mode_xfer = rev_dn || rev_up || (MODE_I == mtu_pkg::MODE_RSYNC &&
                       mt_a[mtu_pkg::CH_P]);

    always_comb begin
        mtu_pkg::mtu_cfg_s cf;
        logic pq;
        logic dn;
        logic [2:0] set;
        logic [2:0] clr;
        cf = mtu_pkg::CFG_RST;
        pq = 1'b0;
        dn = 1'b0;
        set = 3'h0;
        clr = 3'h0;
        next_s = s;
        next_s.pre = s.pre + 3'h1;
        if (rev_dn) begin
            next_s.down = 1'b1;
        end else if (rev_up) begin
            next_s.down = 1'b0;
        end
        for (int c = 0; c < NCH; c++) begin
            cf = s.cfg[c];
            pq = c == mtu_pkg::CH_P || c == mtu_pkg::CH_Q;
            dn = pq && s.down && MODE_I == mtu_pkg::MODE_COMP;
            // CPU preset beats any count or clear this cycle
            if (CNT_WR_I[c] || (SYNC_I[c] && wr_sync)) begin
                next_s.cnt[c] = WR_DATA_I;
            end else if (own_clr[c] || (SYNC_I[c] && sync_clr &&
                cf.counter_clear_source == mtu_pkg::CLR_SYNC)) begin
                next_s.cnt[c] = mtu_pkg::CNT_RST;
            end else if (tick[c]) begin
                next_s.cnt[c] = dn ? s.cnt[c] - 16'h1
                                   : s.cnt[c] + 16'h1;
            end
            if (pq && MODE_I != mtu_pkg::MODE_NORMAL) begin
                if (mode_xfer && BUF_A_I[c]) begin
                    next_s.general_register_a[c] = s.bra[c];
                end
                if (mode_xfer && BUF_B_I[c]) begin
                    next_s.general_register_b[c] = s.brb[c];
                end
            end else begin
                if (mt_a[c] && BUF_A_I[c]) begin
                    next_s.general_register_a[c] = s.bra[c];
                end
                if (mt_b[c] && BUF_B_I[c]) begin
                    next_s.general_register_b[c] = s.brb[c];
                end
                if (cap_a[c]) begin
                    next_s.general_register_a[c] = s.cnt[c];
                    if (BUF_A_I[c]) begin
                        next_s.bra[c] = s.general_register_a[c];
                    end
                end
                if (cap_b[c]) begin
                    next_s.general_register_b[c] = s.cnt[c];
                    if (BUF_B_I[c]) begin
                        next_s.brb[c] = s.general_register_b[c];
                    end
                end
            end
            if (GRA_WR_I[c]) begin
                next_s.general_register_a[c] = WR_DATA_I;
            end
            if (GRB_WR_I[c]) begin
                next_s.general_register_b[c] = WR_DATA_I;
            end
            if (BRA_WR_I[c]) begin
                next_s.bra[c] = WR_DATA_I;
            end
            if (BRB_WR_I[c]) begin
                next_s.brb[c] = WR_DATA_I;
            end
            // Equal A and B cancel out, so the level holds
            if (PWM_I[c]) begin
                if (mt_a[c] && !mt_b[c]) begin
                    next_s.pin_a[c] = 1'b1;
                end else if (mt_b[c] && !mt_a[c]) begin
                    next_s.pin_a[c] = 1'b0;
                end
            end else begin
                if (mt_a[c]) begin
                    next_s.pin_a[c] = pin_lvl(cf.pin_fn_a, s.pin_a[c],
                        c != mtu_pkg::CH_NOTOG);
                end
                if (mt_b[c]) begin
                    next_s.pin_b[c] = pin_lvl(cf.pin_fn_b, s.pin_b[c],
                        c != mtu_pkg::CH_NOTOG);
                end
            end
            set = 3'h0;
            set[mtu_pkg::FLG_A] = mt_a[c] || cap_a[c];
            set[mtu_pkg::FLG_B] = mt_b[c] || cap_b[c];
            set[mtu_pkg::FLG_WRAP] = tick[c] && !dn &&
                                     s.cnt[c] == mtu_pkg::CNT_MAX;
            // Set wins over a clear in the same cycle
            clr = s.armed[c] & ~FLAG_WDATA_I & {3{FLAG_CLR_I[c]}};
            next_s.flg[c] = (s.flg[c] & ~clr) | set;
            if (FLAG_RD_I[c]) begin
                next_s.armed[c] = s.flg[c];
            end else if (FLAG_CLR_I[c]) begin
                next_s.armed[c] = 3'h0;
            end
            if (CFG_WR_I[c]) begin
                next_s.cfg[c] = CFG_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            s <= mtu_pkg::ST_RST;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            IRQ_O[c] = |(s.flg[c] & s.cfg[c].irq_en);
            PIN_A_OE_N_O[c] = !(PWM_I[c] || (!cap_am[c] &&
                              s.cfg[c].pin_fn_a != mtu_pkg::FN_NONE));
            PIN_B_OE_N_O[c] = !(!PWM_I[c] && !cap_bm[c] &&
                              s.cfg[c].pin_fn_b != mtu_pkg::FN_NONE);
        end
    end

    assign CNT_O = s.cnt;
    assign GRA_O = s.general_register_a;
    assign GRB_O = s.general_register_b;
    assign BRA_O = s.bra;
    assign BRB_O = s.brb;
    assign FLAG_O = s.flg;
    assign PIN_A_O = s.pin_a;
    assign PIN_B_O = s.pin_b;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence seq_arm;
        FLAG_RD_I[0] && s.flg[0][mtu_pkg::FLG_A];
    endsequence
    sequence seq_zero;
        !FLAG_RD_I[0] && FLAG_CLR_I[0] &&
        !FLAG_WDATA_I[mtu_pkg::FLG_A] && !mt_a[0] && !cap_a[0];
    endsequence

    a_run_gate_hold: assert property (
        !RUN_I[0] && CNT_WR_I == 5'h0 &&
        s.cfg[0].counter_clear_source == mtu_pkg::CLR_NONE
        |=> CNT_O[0] == $past(CNT_O[0]))
        else $error("stopped counter moved");
    a_wrap_flag_set: assert property (
        tick[0] && CNT_O[0] == 16'hffff && CNT_WR_I == 5'h0 &&
        PWM_I[0] == 1'b0 &&
        s.cfg[0].counter_clear_source == mtu_pkg::CLR_NONE
        |=> CNT_O[0] == 16'h0000 && FLAG_O[0][mtu_pkg::FLG_WRAP])
        else $error("wrap did not zero counter and set flag");
    a_period_clear_a: assert property (
        mt_a[1] && CNT_WR_I == 5'h0 &&
        s.cfg[1].counter_clear_source == mtu_pkg::CLR_A
        |=> CNT_O[1] == 16'h0000 && FLAG_O[1][mtu_pkg::FLG_A])
        else $error("match A clear failed");
    a_match_irq_out: assert property (
        FLAG_O[1][mtu_pkg::FLG_A] && s.cfg[1].irq_en[mtu_pkg::FLG_A]
        |-> IRQ_O[1])
        else $error("enabled flag gave no interrupt");
    a_cpu_write_wins: assert property (
        CNT_WR_I[2] |=> CNT_O[2] == $past(WR_DATA_I))
        else $error("counter write lost");
    a_sync_preset_copy: assert property (
        CNT_WR_I[0] && SYNC_I[0] && SYNC_I[4]
        |=> CNT_O[4] == $past(WR_DATA_I))
        else $error("synchronized preset missed");
    a_pwm_pin_high: assert property (
        PWM_I[4] && mt_a[4] && !mt_b[4] |=> PIN_A_O[4])
        else $error("PWM pin not high after match A");
    a_pwm_equal_hold: assert property (
        PWM_I[4] && mt_a[4] && mt_b[4] |=> $stable(PIN_A_O[4]))
        else $error("PWM pin changed on equal match");
    a_flag_clear_seq: assert property (
        seq_arm ##1 (!FLAG_RD_I[0] && !FLAG_CLR_I[0]) ##1 seq_zero
        |=> !FLAG_O[0][mtu_pkg::FLG_A])
        else $error("armed flag clear failed");
    a_flag_clear_guard: assert property (
        !s.armed[0][mtu_pkg::FLG_A] && FLAG_O[0][mtu_pkg::FLG_A] &&
        FLAG_CLR_I[0] |=> FLAG_O[0][mtu_pkg::FLG_A])
        else $error("unarmed write cleared flag");
    a_cap_buffer_move: assert property (
        cap_a[3] && BUF_A_I[3] && !GRA_WR_I[3] && !BRA_WR_I[3]
        |=> GRA_O[3] == $past(CNT_O[3]) && BRA_O[3] == $past(GRA_O[3]))
        else $error("capture buffer move wrong");
    a_no_toggle_ch2: assert property (
        !PWM_I[2] && mt_a[2] && s.cfg[2].pin_fn_a == mtu_pkg::FN_TOG
        |=> $stable(PIN_A_O[2]))
        else $error("channel 2 toggled");
endmodule : mtu_timer

// file: verification/mtu_pin_model.sv
`timescale 1ns/1ps
module mtu_pin_model (
    input wire logic clk_i,   // Core clock
    output logic [3:0] ext_o, // Count pins
    output logic [4:0] cap_o  // Capture pins
);
    initial begin
        ext_o = '0;
        cap_o = '0;
    end
    // Three clocks a level also satisfies both-edge counting
    task automatic burst(input int n, input int w);
        repeat (n) begin
            repeat (w) @(posedge clk_i);
            ext_o[0] <= 1'b1;
            repeat (w) @(posedge clk_i);
            ext_o[0] <= 1'b0;
        end
    endtask : burst
    task automatic flip(input int ch);
        repeat (3) @(posedge clk_i);
        cap_o[ch] <= ~cap_o[ch];
        repeat (3) @(posedge clk_i);
    endtask : flip
endmodule : mtu_pin_model

// file: verification/mtu_timer_tb.sv
`timescale 1ns/1ps
module mtu_timer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] run = '0, sync = '0, pwm = '0, bufa = '0, cfgw = '0;
    logic [4:0] fr = '0, fc = '0;
    logic [2:0] fwd = '0;
    logic [1:0] mode = '0;
    logic [4:0][4:0] ws = '0;
    logic [15:0] wd = '0;
    mtu_pkg::mtu_cfg_s cfg = mtu_pkg::CFG_RST;
    logic [4:0][15:0] cnt, general_register_a, bra;
    logic [4:0][2:0] flag;
    logic [4:0] irq, pa, paoe, cap;
    logic [3:0] ext;
    int failures = 0, n_checks = 0;
    int v, w, hi, ga;
    always #2.5 clk = ~clk;
    mtu_pin_model u_mtu_pin_model (.clk_i(clk), .ext_o(ext), .cap_o(cap));
    mtu_timer u_mtu_timer (.CORE_CLK_I(clk), .SYS_RST_I(rst), .RUN_I(run),
        .SYNC_I(sync), .PWM_I(pwm), .MODE_I(mode), .BUF_A_I(bufa),
        .BUF_B_I(5'h00), .CFG_WR_I(cfgw), .CFG_I(cfg), .WR_DATA_I(wd),
        .CNT_WR_I(ws[0]), .GRA_WR_I(ws[1]), .GRB_WR_I(ws[2]),
        .BRA_WR_I(ws[3]), .BRB_WR_I(ws[4]), .FLAG_RD_I(fr),
        .FLAG_CLR_I(fc), .FLAG_WDATA_I(fwd), .EXT_CLK_I(ext),
        .PIN_A_I(cap), .PIN_B_I(5'h00), .CNT_O(cnt), .GRA_O(general_register_a),
        .GRB_O(), .BRA_O(bra), .BRB_O(), .FLAG_O(flag), .IRQ_O(irq),
        .PIN_A_O(pa), .PIN_A_OE_N_O(paoe), .PIN_B_O(), .PIN_B_OE_N_O());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input int k, input int ch, input logic [15:0] d);
        @(posedge clk);
        wd <= d;
        ws[k][ch] <= 1'b1;
        tick(1);
        ws <= '0;
    endtask : wr
    task automatic setcfg(input int ch, input logic [2:0] src,
        input logic [1:0] edg, input logic [1:0] clr,
        input logic [2:0] fa, input logic [2:0] ie);
        @(posedge clk);
        cfg <= '{src, edg, clr, fa, 3'h0, ie};
        cfgw[ch] <= 1'b1;
        tick(1);
        cfgw <= '0;
    endtask : setcfg
    task automatic flg(input int ch, input bit rd);
        @(posedge clk);
        if (rd) fr[ch] <= 1'b1;
        else fc[ch] <= 1'b1;
        tick(1);
        fr <= '0;
        fc <= '0;
    endtask : flg
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        v = $urandom(58);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(cnt[0], 16'h0000);
        chk(16'(paoe), 16'h001f);
        v = $urandom % 8;
        setcfg(0, 3'h0, 2'h0, 2'h0, 3'h0, 3'h4);
        wr(0, 0, 16'hffff - 16'(v));
        @(posedge clk);
        run <= 5'h01;
        tick(v + 3);
        chk(cnt[0], 16'h0002);
        // Reset registers are ffff, so both compare flags rise at the wrap
        chk(16'(flag[0]), 16'h0007);
        chk(16'(irq), 16'h0001);
        chk(cnt[4], 16'h0000);
        run <= '0;
        tick(1);
        w = cnt[0];
        tick(5);
        chk(cnt[0], 16'(w));
        flg(0, 0);
        chk(16'(flag[0]), 16'h0007);
        flg(0, 1);
        fwd <= 3'h3;
        flg(0, 0);
        chk(16'(flag[0]), 16'h0003);
        fwd <= 3'h0;
        flg(0, 1);
        flg(0, 0);
        chk(16'(flag[0]), 16'h0000);
        chk(16'(irq), 16'h0000);
        // Period 4 first, then the buffered 6 takes over at the match
        setcfg(1, 3'h0, 2'h0, 2'h1, 3'h3, 3'h1);
        wr(1, 1, 16'h0003);
        wr(3, 1, 16'h0006);
        bufa <= 5'h02;
        run <= 5'h02;
        tick(3);
        chk(cnt[1], 16'h0003);
        chk(16'(pa), 16'h0000);
        tick(1);
        chk(cnt[1], 16'h0000);
        chk(general_register_a[1], 16'h0006);
        chk(16'(flag[1]), 16'h0001);
        chk(16'(irq), 16'h0002);
        chk(16'(pa), 16'h0002);
        tick(7);
        chk(16'(pa), 16'h0000);
        run <= '0;
        // Toggle request on channel 2 must leave its pin alone
        wr(1, 2, 16'h0004);
        for (int s = 0; s < 4; s++) begin
            setcfg(2, 3'(s), 2'h0, 2'h0, 3'h3, 3'h0);
            wr(0, 2, 16'h0000);
            run <= 5'h04;
            repeat (64) @(posedge clk);
            run <= '0;
            tick(1);
            chk(cnt[2], 16'(64 >> s));
            chk(16'(pa[2]), 16'h0000);
        end
        for (int e = 0; e < 3; e++) begin
            setcfg(2, 3'h4, 2'(e), 2'h0, 3'h0, 3'h0);
            wr(0, 2, 16'h0000);
            run <= 5'h04;
            u_mtu_pin_model.burst(5, 3);
            tick(8);
            chk(cnt[2], 16'((e == 2) ? 10 : 5));
        end
        // Stopped counter makes the captured value exact
        run <= '0;
        bufa <= 5'h08;
        setcfg(3, 3'h0, 2'h0, 2'h0, 3'h4, 3'h0);
        v = $urandom;
        wr(0, 3, 16'(v));
        u_mtu_pin_model.flip(3);
        tick(4);
        chk(general_register_a[3], 16'(v));
        chk(bra[3], 16'hffff);
        setcfg(3, 3'h0, 2'h0, 2'h0, 3'h5, 3'h0);
        w = $urandom;
        wr(0, 3, 16'(w));
        u_mtu_pin_model.flip(3);
        tick(4);
        chk(general_register_a[3], 16'(w));
        chk(bra[3], 16'(v));
        mode <= 2'h1;
        wr(0, 3, 16'h0000);
        wr(1, 3, 16'h0002);
        wr(3, 3, 16'h0005);
        run <= 5'h08;
        tick(3);
        chk(cnt[3], 16'h0000);
        chk(general_register_a[3], 16'h0005);
        run <= '0;
        mode <= 2'h0;
        sync <= 5'h11;
        v = $urandom;
        wr(0, 0, 16'(v));
        chk(cnt[4], 16'(v));
        // Channel 0 stays synced and follows channel 4's period clear
        setcfg(0, 3'h0, 2'h0, 2'h3, 3'h0, 3'h0);
        for (int i = 0; i < 3; i++) begin
            ga = (i == 0) ? 2 : ((i == 1) ? 8 : 6);
            setcfg(4, 3'h0, 2'h0, 2'h2, 3'h0, 3'h0);
            wr(0, 4, 16'h0000);
            wr(1, 4, 16'(ga));
            wr(2, 4, 16'h0006);
            pwm <= 5'h10;
            run <= 5'h11;
            tick(14);
            hi = 0;
            repeat (70) begin
                tick(1);
                hi += int'(pa[4]);
            end
            chk(16'(hi), 16'((ga < 6) ? 10 * (6 - ga) : 0));
            chk(16'(paoe[4]), 16'h0000);
            chk(cnt[0], 16'h0000);
            run <= '0;
        end
        report_and_stop();
    end
endmodule : mtu_timer_tb
